// file: charger_regs.vh
`ifndef CHARGER_REGS_VH
`define CHARGER_REGS_VH

// bus address and register map
`define DEV_ADDR 7'h09
`define IDX_SRC_CTRL 8'h00
`define IDX_PWR_CFG 8'h01
`define IDX_MISC_CTRL 8'h06
`define RST_SRC_CTRL 8'h4F
`define RST_PWR_CFG 8'h04
`define RST_MISC_CTRL 8'h00

// field positions
`define BIT_HIZ 7
`define BIT_REG_RESET 7
`define BIT_WD_RESET 6
`define BIT_CHG_INHIBIT 3
`define BIT_DISCONNECT 5
`define MSB_VIN_MIN 6
`define LSB_VIN_MIN 3
`define MSB_IIN_LIM 2
`define MSB_UVLO 2
`define PWR_CFG_WMASK 8'h0F

// alert-line timing, clock 250 MHz
`define CLK_HZ 250000000
`define EXIT_SHIP_MS 500
`define RESET_HOLD_S 8
`define CNT_W 32

// bit counter values
`define BIT_LAST 4'h7
`define BIT_ACK 4'h8
`define BIT_PRE 4'hF

`endif

// file: pin_sync.v
`timescale 1ns/1ps
// two-stage synchroniser for pins from outside the clock domain
module pin_sync (
    core_clk,
    rst_n,
    clk_en,
    pin_in,
    pin_sync_out
);
    input wire core_clk;
    input wire rst_n;
    input wire clk_en;
    input wire pin_in;
    output reg pin_sync_out;

    reg meta_r;

    // resets high: idle level of the open-drain lines
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= 1'b1;
            pin_sync_out <= 1'b1;
        end else if (clk_en) begin
            meta_r <= pin_in;
            pin_sync_out <= meta_r;
        end
    end
endmodule // pin_sync

// file: charger_i2c_slave_ship_ctrl.v
// Functional notes
// RULE1: host writing 1 to disconnect request turns battery switch off, shipping mode.
// RULE2: disconnect request bit self-clears once battery switch turns on again.
// RULE3: in shipping mode, alert low over 500ms turns battery switch on.
// RULE4: with switch on, alert low over 8s turns battery switch off.
// RULE5: slave only; clock line never driven, master starts every transaction.
// RULE6: works at 100kbit/s and 400kbit/s bus rates.
// RULE7: start and stop conditions detected while clock line high.
// RULE8: transmitter changes data only while clock line low.
// RULE9: bytes are 8 bits, msb first, unlimited bytes per transfer.
// RULE10: receiver pulls data low through ninth clock to acknowledge.
// RULE11: after not-acknowledge master sends stop or repeated start.
// RULE12: address 09h plus direction bit; respond only on match.
// RULE13: single write: address, index, data; data stored at indexed register.
// RULE14: single read: index written, repeated start, one byte returned.
// RULE15: input source bit 7 opens only the input-to-system switch.
// RULE16: input source bits 6..3 set minimum input voltage, reset code 1001.
// RULE17: input source bits 2..0 select input current ceiling, reset 111.
// RULE18: config bit 7 resets registers, bit 6 restarts watchdog; zero ignored.
// RULE19: config bit 3 inhibits charging; bits 2..0 set undervoltage cutoff.
// RULE20: register index advances by one after each data byte.
// RULE21: alert timers use internal clock, restart on rise, act once per low.
// RULE22: starts in default mode; any register write enters host mode (a config write with bit 7 set returns to default mode instead).
`timescale 1ns/1ps
`include "charger_regs.vh"
module charger_i2c_slave_ship_ctrl (
    core_clk,
    rst_n,
    clk_en,
    scl_in,
    sda_in,
    sda_out,
    sda_oe,
    alert_in,
    battery_switch_on,
    shipping_mode,
    input_high_impedance_enable,
    vin_min_code,
    iin_lim_code,
    charge_inhibit,
    battery_undervoltage_cutoff,
    host_mode,
    watchdog_restart
);
    input wire core_clk;
    input wire rst_n;
    input wire clk_en;
    input wire scl_in;
    input wire sda_in;
    output wire sda_out;
    output reg sda_oe;
    input wire alert_in;
    output reg battery_switch_on;
    output reg shipping_mode;
    output reg input_high_impedance_enable;
    output reg [3:0] vin_min_code;
    output reg [2:0] iin_lim_code;
    output reg charge_inhibit;
    output reg [2:0] battery_undervoltage_cutoff;
    output reg host_mode;
    output reg watchdog_restart;

    // ticks from milliseconds / seconds at the core clock rate
    localparam [`CNT_W-1:0] EXIT_CYC = (`CLK_HZ / 1000) * `EXIT_SHIP_MS;
    localparam [`CNT_W-1:0] RESET_CYC = `CLK_HZ * `RESET_HOLD_S;
    localparam [7:0] SRC_RST = `RST_SRC_CTRL;
    localparam [7:0] CFG_RST = `RST_PWR_CFG;

    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_ADDR = 5'h02;
    localparam [4:0] ST_WRITE = 5'h04;
    localparam [4:0] ST_READ = 5'h08;
    localparam [4:0] ST_ACKCHK = 5'h10;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    wire scl_s;
    wire sda_s;
    wire alert_s;

    pin_sync u_scl (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .pin_in(scl_in),
        .pin_sync_out(scl_s)
    );
    pin_sync u_sda (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .pin_in(sda_in),
        .pin_sync_out(sda_s)
    );
    pin_sync u_alert (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .pin_in(alert_in),
        .pin_sync_out(alert_s)
    );

    reg scl_d_r;
    reg sda_d_r;
    reg alert_d_r;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            alert_d_r <= 1'b1;
        end else if (clk_en) begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
            alert_d_r <= alert_s;
        end
    end

    // 250 MHz oversamples a 400 kHz clock by >600x, ample for edge finding
    wire scl_rise = scl_s & ~scl_d_r; // see RULE6
    wire scl_fall = ~scl_s & scl_d_r;
    wire start_det = scl_s & scl_d_r & ~sda_s & sda_d_r; // see RULE7
    wire stop_det = scl_s & scl_d_r & sda_s & ~sda_d_r; // see RULE7

    ////////////////////////////////////////////////////////////////////////
    // registers
    reg [7:0] src_ctrl_r;
    reg [7:0] pwr_cfg_r;
    reg disc_req_r;

    function [7:0] reg_read;
        input [7:0] idx;
        input [7:0] src;
        input [7:0] cfg;
        input disc;
        begin
            case (idx)
                `IDX_SRC_CTRL: reg_read = src;
                `IDX_PWR_CFG: reg_read = cfg & `PWR_CFG_WMASK;
                `IDX_MISC_CTRL: reg_read = {2'b00, disc, 5'b00000};
                default: reg_read = 8'h00;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // serial engine; sda only, clock line is input-only
    reg [4:0] state_r;
    reg [3:0] bit_r;
    reg [7:0] shift_r;
    reg [7:0] index_r;
    reg idx_phase_r;
    reg wr_stb_r;
    reg [7:0] wr_data_r;
    reg [7:0] wr_idx_r;
    reg drive_low_r;
    wire [7:0] rd_byte = reg_read(index_r, src_ctrl_r, pwr_cfg_r, disc_req_r);

    assign sda_out = 1'b0; // see RULE5
    always @* begin
        sda_oe = drive_low_r;
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            bit_r <= 4'h0;
            shift_r <= 8'h00;
            index_r <= 8'h00;
            idx_phase_r <= 1'b0;
            wr_stb_r <= 1'b0;
            wr_data_r <= 8'h00;
            wr_idx_r <= 8'h00;
            drive_low_r <= 1'b0;
        end else if (clk_en) begin
            wr_stb_r <= 1'b0;
            if (stop_det) begin
                state_r <= ST_IDLE;
                drive_low_r <= 1'b0;
            end else if (start_det) begin
                // repeated start keeps the index
                state_r <= ST_ADDR;
                // the clock fall that closes the start is not a data bit
                bit_r <= `BIT_PRE;
                drive_low_r <= 1'b0;
            end else begin
                case (state_r)
                    ST_IDLE: begin
                        drive_low_r <= 1'b0;
                    end
                    ST_ADDR, ST_WRITE: begin
                        if (scl_rise && bit_r <= `BIT_LAST) begin
                            shift_r <= {shift_r[6:0], sda_s}; // see RULE9
                        end else if (scl_fall) begin
                            if (bit_r == `BIT_LAST) begin
                                bit_r <= `BIT_ACK;
                                if (state_r == ST_ADDR) begin
                                    if (shift_r[7:1] == `DEV_ADDR) begin // see RULE12
                                        drive_low_r <= 1'b1; // see RULE10
                                    end else begin
                                        state_r <= ST_IDLE;
                                    end
                                end else begin
                                    drive_low_r <= 1'b1; // see RULE10
                                    if (!idx_phase_r) begin
                                        index_r <= shift_r;
                                        idx_phase_r <= 1'b1;
                                    end else begin
                                        wr_stb_r <= 1'b1; // see RULE13
                                        wr_data_r <= shift_r;
                                        wr_idx_r <= index_r;
                                        index_r <= index_r + 8'h01; // see RULE20
                                    end
                                end
                            end else if (bit_r == `BIT_ACK) begin
                                drive_low_r <= 1'b0;
                                bit_r <= 4'h0;
                                if (state_r == ST_ADDR) begin
                                    if (shift_r[0]) begin
                                        // read: first data bit goes out now
                                        state_r <= ST_READ; // see RULE14
                                        shift_r <= rd_byte;
                                        drive_low_r <= ~rd_byte[7];
                                    end else begin
                                        state_r <= ST_WRITE;
                                        idx_phase_r <= 1'b0;
                                    end
                                end
                            end else begin
                                bit_r <= bit_r + 4'h1;
                            end
                        end
                    end
                    ST_READ: begin
                        // data changes only on falling clock edges
                        if (scl_fall) begin // see RULE8
                            if (bit_r == `BIT_LAST) begin
                                drive_low_r <= 1'b0;
                                bit_r <= `BIT_ACK;
                                index_r <= index_r + 8'h01; // see RULE20
                            end else begin
                                bit_r <= bit_r + 4'h1;
                                shift_r <= {shift_r[6:0], 1'b0};
                                drive_low_r <= ~shift_r[6];
                            end
                        end
                        if (scl_rise && bit_r == `BIT_ACK) begin
                            state_r <= ST_ACKCHK;
                            idx_phase_r <= sda_s; // 1 = master nack
                        end
                    end
                    ST_ACKCHK: begin
                        if (scl_fall) begin
                            bit_r <= 4'h0;
                            if (idx_phase_r) begin
                                // wait for stop or repeated start
                                state_r <= ST_IDLE; // see RULE11
                            end else begin
                                state_r <= ST_READ;
                                shift_r <= rd_byte;
                                drive_low_r <= ~rd_byte[7];
                            end
                        end
                    end
                    default: begin
                        state_r <= ST_IDLE;
                        drive_low_r <= 1'b0;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register writes and battery disconnect
    reg [`CNT_W-1:0] low_cnt_r;
    reg exit_done_r;
    reg reset_done_r;
    wire alert_low = ~alert_s;
    wire alert_rise = alert_s & ~alert_d_r;
    wire sw_on_evt = shipping_mode && alert_low && !exit_done_r
        && low_cnt_r >= EXIT_CYC; // see RULE3
    wire sw_off_evt = battery_switch_on && alert_low && !reset_done_r
        && low_cnt_r >= RESET_CYC; // see RULE4
    wire reg_reset = wr_stb_r && wr_idx_r == `IDX_PWR_CFG
        && wr_data_r[`BIT_REG_RESET];

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt_r <= {`CNT_W{1'b0}};
            exit_done_r <= 1'b0;
            reset_done_r <= 1'b0;
        end else if (clk_en) begin
            if (alert_rise || !alert_low) begin // see RULE21
                low_cnt_r <= {`CNT_W{1'b0}};
                exit_done_r <= 1'b0;
                reset_done_r <= 1'b0;
            end else begin
                if (low_cnt_r != {`CNT_W{1'b1}}) begin
                    low_cnt_r <= low_cnt_r + 1'b1;
                end
                if (sw_on_evt) begin
                    exit_done_r <= 1'b1; // see RULE21
                    reset_done_r <= 1'b1;
                end
                if (sw_off_evt) begin
                    reset_done_r <= 1'b1; // see RULE21
                    exit_done_r <= 1'b1;
                end
            end
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            src_ctrl_r <= `RST_SRC_CTRL; // see RULE22
            pwr_cfg_r <= `RST_PWR_CFG;
            disc_req_r <= 1'b0;
            battery_switch_on <= 1'b1;
            shipping_mode <= 1'b0;
            host_mode <= 1'b0; // see RULE22
            watchdog_restart <= 1'b0;
        end else if (clk_en) begin
            watchdog_restart <= 1'b0;
            // alert events first: a host request in the same cycle must win
            if (sw_on_evt) begin
                battery_switch_on <= 1'b1;
                shipping_mode <= 1'b0;
                disc_req_r <= 1'b0; // see RULE2
            end else if (sw_off_evt) begin
                battery_switch_on <= 1'b0; // see RULE4
            end else if (!battery_switch_on && !shipping_mode && alert_rise) begin
                battery_switch_on <= 1'b1; // reset mode ends when alert released
                disc_req_r <= 1'b0; // see RULE2
            end
            if (reg_reset) begin
                src_ctrl_r <= `RST_SRC_CTRL; // see RULE18
                pwr_cfg_r <= `RST_PWR_CFG;
                disc_req_r <= 1'b0;
                host_mode <= 1'b0;
                watchdog_restart <= wr_data_r[`BIT_WD_RESET];
            end else if (wr_stb_r) begin
                host_mode <= 1'b1; // see RULE22
                case (wr_idx_r)
                    `IDX_SRC_CTRL: src_ctrl_r <= wr_data_r; // see RULE13
                    `IDX_PWR_CFG: begin
                        pwr_cfg_r <= wr_data_r & `PWR_CFG_WMASK; // see RULE19
                        watchdog_restart <= wr_data_r[`BIT_WD_RESET]; // see RULE18
                    end
                    `IDX_MISC_CTRL: begin
                        if (wr_data_r[`BIT_DISCONNECT]) begin
                            disc_req_r <= 1'b1;
                            battery_switch_on <= 1'b0; // see RULE1
                            shipping_mode <= 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // field outputs
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            input_high_impedance_enable <= SRC_RST[`BIT_HIZ];
            vin_min_code <= SRC_RST[`MSB_VIN_MIN:`LSB_VIN_MIN];
            iin_lim_code <= SRC_RST[`MSB_IIN_LIM:0];
            charge_inhibit <= CFG_RST[`BIT_CHG_INHIBIT];
            battery_undervoltage_cutoff <= CFG_RST[`MSB_UVLO:0];
        end else if (clk_en) begin
            input_high_impedance_enable <= src_ctrl_r[`BIT_HIZ]; // see RULE15
            vin_min_code <= src_ctrl_r[`MSB_VIN_MIN:`LSB_VIN_MIN]; // see RULE16
            iin_lim_code <= src_ctrl_r[`MSB_IIN_LIM:0]; // see RULE17
            charge_inhibit <= pwr_cfg_r[`BIT_CHG_INHIBIT]; // see RULE19
            battery_undervoltage_cutoff <= pwr_cfg_r[`MSB_UVLO:0]; // see RULE19
        end
    end
endmodule // charger_i2c_slave_ship_ctrl

// file: charger_ship_chk.sv
`timescale 1ns/1ps
module charger_ship_chk (
    input wire core_clk,
    input wire rst_n,
    input wire clk_en,
    input wire scl_in,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe,
    input wire alert_in,
    input wire battery_switch_on,
    input wire shipping_mode,
    input wire input_high_impedance_enable,
    input wire [3:0] vin_min_code,
    input wire [2:0] iin_lim_code,
    input wire charge_inhibit,
    input wire [2:0] battery_undervoltage_cutoff,
    input wire host_mode,
    input wire watchdog_restart
);
    reg [31:0] alert_low_r;
    wire [31:0] alert_low_nxt = alert_in ? 32'h0 : alert_low_r + 32'h1;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            alert_low_r <= 32'h0;
        else
            alert_low_r <= alert_low_nxt;
    end
    ////////////////////////////////////////
    property p_sda_out_low;
        @(posedge core_clk) disable iff (!rst_n) sda_out == 1'b0;
    endproperty
    a_sda_out_low: assert property (p_sda_out_low) else $error("data pin driven high");
    property p_oe_rise;
        @(posedge core_clk) disable iff (!rst_n) $rose(sda_oe) |-> $past(!scl_in, 2);
    endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("data pull began in clock high");
    property p_oe_hold;
        @(posedge core_clk) disable iff (!rst_n) sda_oe && scl_in |=> sda_oe;
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("data pull dropped in clock high");
    // async reset: checked while reset is held, so no disable here
    property p_reset_vals;
        @(posedge core_clk) !rst_n |-> battery_switch_on && !shipping_mode && !sda_oe
            && !host_mode && vin_min_code == 4'h9 && iin_lim_code == 3'h7
            && battery_undervoltage_cutoff == 3'h4 && !charge_inhibit;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad value in reset");
    property p_ship_off;
        @(posedge core_clk) disable iff (!rst_n) shipping_mode |-> !battery_switch_on;
    endproperty
    a_ship_off: assert property (p_ship_off) else $error("switch on in shipping");
    property p_wd_pulse;
        @(posedge core_clk) disable iff (!rst_n) watchdog_restart |=> !watchdog_restart;
    endproperty
    a_wd_pulse: assert property (p_wd_pulse) else $error("restart pulse too long");
    property p_field_chg;
        @(posedge core_clk) disable iff (!rst_n)
            $changed({input_high_impedance_enable, vin_min_code, iin_lim_code,
            charge_inhibit, battery_undervoltage_cutoff}) |-> $past(!scl_in, 4);
    endproperty
    a_field_chg: assert property (p_field_chg) else $error("field moved off a write");
    property p_alert_off;
        @(posedge core_clk) disable iff (!rst_n)
            $fell(battery_switch_on) && !shipping_mode && !alert_in
            |-> alert_low_r > 32'd1999999990;
    endproperty
    a_alert_off: assert property (p_alert_off) else $error("switch off too early");
endmodule // charger_ship_chk

// file: i2c_host_model.sv
`timescale 1ns/1ps
module i2c_host_model (
    scl,
    sda_pull,
    sda
);
    output reg scl;
    output reg sda_pull;
    input wire sda;
    // clock stands still high between frames
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // data moves late in the low phase, after the slave has seen the fall
    task send_bit(input b);
        begin
            #16 sda_pull = ~b;
            #8 scl = 1'b1;
            #24 scl = 1'b0;
        end
    endtask
    task recv_bit(output b);
        begin
            #16 sda_pull = 1'b0;
            #8 scl = 1'b1;
            #12 b = sda;
            #12 scl = 1'b0;
        end
    endtask
    task start_cond;
        begin
            #16 sda_pull = 1'b0;
            #8 scl = 1'b1;
            #12 sda_pull = 1'b1;
            #12 scl = 1'b0;
        end
    endtask
    task stop_cond;
        begin
            #16 sda_pull = 1'b1;
            #8 scl = 1'b1;
            #12 sda_pull = 1'b0;
            #12;
        end
    endtask
    task send_byte(input [7:0] b, output ack);
        integer i;
        reg a;
        begin
            for (i = 7; i >= 0; i = i - 1)
                send_bit(b[i]);
            recv_bit(a);
            ack = ~a;
        end
    endtask
    task recv_byte(input last, output [7:0] d);
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1)
                recv_bit(d[i]);
            send_bit(last);
        end
    endtask
endmodule // i2c_host_model

// file: tb_charger_i2c_slave_ship_ctrl.sv
`timescale 1ns/1ps
`include "charger_regs.vh"
`define CHECK(g, e) begin tests_run = tests_run + 1; if ((g) !== (e)) begin \
    n_errors = n_errors + 1; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module tb_charger_i2c_slave_ship_ctrl;
    reg core_clk, rst_n, alert_in, ack_bit;
    wire scl, host_pull, sda_out, sda_oe, bsw, ship, hiz, inh, hm, wd;
    wire [3:0] vin;
    wire [2:0] iin, uvlo;
    // pulled-up data wire
    wire sda = ~host_pull & (sda_oe ? sda_out : 1'b1);
    integer n_errors, tests_run, wd_seen, wd_exp;
    reg [31:0] r;
    reg [7:0] mdl [0:7];
    reg hm_exp;
    charger_i2c_slave_ship_ctrl dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .alert_in(alert_in),
        .battery_switch_on(bsw), .shipping_mode(ship), .input_high_impedance_enable(hiz),
        .vin_min_code(vin), .iin_lim_code(iin), .charge_inhibit(inh),
        .battery_undervoltage_cutoff(uvlo), .host_mode(hm), .watchdog_restart(wd));
    i2c_host_model host (.scl(scl), .sda_pull(host_pull), .sda(sda));
    always @(negedge core_clk) if (wd === 1'b1) wd_seen = wd_seen + 1;
    ////////////////////////////////////////
    task mdl_reset;
        begin
            mdl[0] = 8'h4F;
            mdl[1] = 8'h04;
            mdl[6] = 8'h00;
            hm_exp = 1'b0;
        end
    endtask
    task mdl_write(input [7:0] a, input [7:0] d);
        begin
            hm_exp = 1'b1;
            if (a == 8'h00) mdl[0] = d;
            if (a == 8'h06) mdl[6] = d;
            if (a == 8'h01) begin
                if (d[6]) wd_exp = wd_exp + 1;
                mdl[1] = {4'h0, d[3:0]};
                if (d[7]) mdl_reset;
            end
        end
    endtask
    function [7:0] mdl_read(input [7:0] a);
        case (a)
            8'h00: mdl_read = mdl[0];
            8'h01: mdl_read = {4'h0, mdl[1][3:0]};
            8'h06: mdl_read = mdl[6];
            default: mdl_read = 8'h00;
        endcase
    endfunction
    task check_outs;
        begin
            `CHECK(hiz, mdl[0][7])
            `CHECK(vin, mdl[0][6:3])
            `CHECK(iin, mdl[0][2:0])
            `CHECK({inh, uvlo}, mdl[1][3:0])
            `CHECK(hm, hm_exp)
            `CHECK({bsw, ship}, {~mdl[6][5], mdl[6][5]})
            `CHECK(wd_seen, wd_exp)
        end
    endtask
    task bus_write(input [7:0] idx, input [7:0] d0, input [7:0] d1, input integer n);
        integer i;
        begin
            host.start_cond;
            host.send_byte({`DEV_ADDR, 1'b0}, ack_bit);
            `CHECK(ack_bit, 1'b1)
            host.send_byte(idx, ack_bit);
            `CHECK(ack_bit, 1'b1)
            for (i = 0; i < n; i = i + 1) begin
                host.send_byte(i ? d1 : d0, ack_bit);
                `CHECK(ack_bit, 1'b1)
                mdl_write(idx + i[7:0], i ? d1 : d0);
            end
            host.stop_cond;
            repeat (8) @(negedge core_clk);
            check_outs;
        end
    endtask
    task bus_read(input [7:0] idx, input integer n);
        integer i;
        reg [7:0] d;
        begin
            host.start_cond;
            host.send_byte({`DEV_ADDR, 1'b0}, ack_bit);
            host.send_byte(idx, ack_bit);
            host.start_cond;
            host.send_byte({`DEV_ADDR, 1'b1}, ack_bit);
            `CHECK(ack_bit, 1'b1)
            for (i = 0; i < n; i = i + 1) begin
                host.recv_byte(i == n - 1, d);
                `CHECK(d, mdl_read(idx + i[7:0]))
            end
            host.stop_cond;
            repeat (8) @(negedge core_clk);
        end
    endtask
    task alert_pulse;
        begin
            alert_in = 1'b0;
            repeat (1000) @(negedge core_clk);
            alert_in = 1'b1;
            repeat (8) @(negedge core_clk);
            check_outs;
        end
    endtask
    task wrap_up;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, n_errors);
            if (n_errors == 0 && tests_run > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    ////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        #200000;
        n_errors = n_errors + 1;
        $display("unexpected at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        wrap_up;
    end
    initial begin
        rst_n = 1'b1;
        alert_in = 1'b1;
        n_errors = 0;
        tests_run = 0;
        wd_seen = 0;
        wd_exp = 0;
        mdl_reset;
        r = $urandom(32'hF446);
        // reset falls after every flop process is waiting, before the first edge
        #1 rst_n = 1'b0;
        repeat (8) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        check_outs;
        bus_read(8'h00, 2);
        $display("test reset values done");
        repeat (6) begin
            r = $urandom;
            bus_write(8'h00, r[7:0], 8'h00, 1);
            bus_read(8'h00, 1);
        end
        $display("test single transfers done");
        r = $urandom;
        bus_write(8'h00, r[7:0], {4'h0, r[11:8]}, 2);
        bus_read(8'h00, 2);
        bus_write(8'h01, {4'h4, r[19:16]}, 8'h00, 1);
        bus_write(8'h01, {4'h0, r[23:20]}, 8'h00, 1);
        $display("test multi byte and restart done");
        host.start_cond;
        host.send_byte(8'h14, ack_bit);
        `CHECK(ack_bit, 1'b0)
        host.stop_cond;
        repeat (8) @(negedge core_clk);
        check_outs;
        $display("test foreign address done");
        bus_write(8'h01, 8'h8F, 8'h00, 1);
        bus_write(8'h01, 8'hC0, 8'h00, 1);
        bus_read(8'h00, 2);
        $display("test register reset done");
        alert_pulse;
        bus_write(8'h06, 8'h20, 8'h00, 1);
        alert_pulse;
        bus_read(8'h06, 2);
        $display("test shipping done");
        wrap_up;
    end
endmodule // tb_charger_i2c_slave_ship_ctrl
bind charger_i2c_slave_ship_ctrl charger_ship_chk u_chk (.core_clk(core_clk), .rst_n(rst_n),
    .clk_en(clk_en), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .alert_in(alert_in), .battery_switch_on(battery_switch_on), .shipping_mode(shipping_mode),
    .input_high_impedance_enable(input_high_impedance_enable), .vin_min_code(vin_min_code),
    .iin_lim_code(iin_lim_code), .charge_inhibit(charge_inhibit),
    .battery_undervoltage_cutoff(battery_undervoltage_cutoff), .host_mode(host_mode),
    .watchdog_restart(watchdog_restart));
